/* File: design/aig_pkg.sv */
// Constants, signature table and symbol arithmetic for the acquisition indicator generator
package aig_pkg;

  // ==========================================================================
  // Frame geometry, counted in chips (one chip per rising clk_sys edge)
  localparam int NUM_SIG = 16;
  localparam int SYM_PER_PART = 32;
  localparam int SLOTS_PER_TRAIN = 15;
  localparam int CHIPS_PER_SYM = 128;
  localparam int PART_CHIPS = 4096;
  localparam int GAP_CHIPS = 1024;
  localparam int FIFO_DEPTH = 32;
  localparam int CODE_W = 8;

  localparam int IND_W = 2 * NUM_SIG;
  localparam int SYM_W = 6;
  localparam int IDX_W = 5;
  localparam int SLOT_W = 4;
  localparam int CNT_W = 11;
  localparam int MON_W = 13;

  localparam logic [IDX_W-1:0] LAST_SYM = 5'h1F;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 4'hE;

  // ==========================================================================
  // Indicator coding, two bits per signature; 2'b10 is read as zero
  localparam logic [1:0] IND_POS = 2'h1;
  localparam logic [1:0] IND_NEG = 2'h3;

  // ==========================================================================
  // Signature sequences: bit j set means element j is -1
  localparam logic [31:0] SIG_TABLE [NUM_SIG] = '{
    32'h00000000, 32'hCCCCCCCC, 32'hF0F0F0F0, 32'h3C3C3C3C,
    32'hFF00FF00, 32'h33CC33CC, 32'h0FF00FF0, 32'hC33CC33C,
    32'hFFFF0000, 32'h3333CCCC, 32'h0F0FF0F0, 32'hC3C33C3C,
    32'h00FFFF00, 32'hCC3333CC, 32'hF00F0FF0, 32'h3CC3C33C
  };

  typedef enum logic [1:0] {
    AIG_IDLE = 2'b00,
    AIG_PART = 2'b01,
    AIG_GAP = 2'b11
  } aig_state_e;

  // ==========================================================================
  // Weighted sum of all signatures at symbol j; ant2 selects the diversity branch,
  // where each pair (b0,b1) of every sequence becomes (-b1,b0) before combining
  function automatic logic signed [SYM_W-1:0] aig_sym_sum(input logic [IND_W-1:0] ind,
                                                         input logic [IDX_W-1:0] j,
                                                         input logic ant2);
    logic signed [SYM_W-1:0] acc;
    logic [IDX_W-1:0] k;
    logic neg;
    logic [1:0] w;
    acc = '0;
    k = ant2 ? (j ^ 5'h01) : j;
    for (int s = 0; s < NUM_SIG; s++) begin
      w = ind[2*s +: 2];
      neg = SIG_TABLE[s][k] ^ (ant2 & ~j[0]);
      if (w == IND_POS) begin
        acc = neg ? acc - 6'sh01 : acc + 6'sh01;
      end else if (w == IND_NEG) begin
        acc = neg ? acc + 6'sh01 : acc - 6'sh01;
      end
    end
    return acc;
  endfunction : aig_sym_sum

endpackage : aig_pkg

/* File: design/aig_stream_if.sv */
// Valid/ready word carrier between the generator and its indicator FIFO
interface aig_stream_if #(parameter int W = 32);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : aig_stream_if

/* File: design/aig_fifo.sv */
// Indicator-set FIFO with registered full/empty flags
module aig_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  aig_stream_if.snk wr,
  aig_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic wr_ready;
    logic rd_valid;
  } aig_fifo_s;

  aig_fifo_s s;
  aig_fifo_s next_s;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // ==========================================================================
  // Flags come from registers so the source sees ready straight off a flop
  assign push = wr.valid & s.wr_ready;
  assign pop = rd.ready & s.rd_valid;
  assign wr.ready = s.wr_ready;
  assign rd.valid = s.rd_valid;
  assign rd.data = mem[s.rptr];

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wptr = s.wptr + 1'b1;
    end
    if (pop) begin
      next_s.rptr = s.rptr + 1'b1;
    end
    next_s.count = s.count + (AW + 1)'(push) - (AW + 1)'(pop);
    next_s.wr_ready = next_s.count != FULL_CNT;
    next_s.rd_valid = next_s.count != '0;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{wptr: '0, rptr: '0, count: '0, wr_ready: 1'b1, rd_valid: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // Storage is kept outside the state word; it needs no reset
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[s.wptr] <= wr.data;
    end
  end

  // ==========================================================================
  fifo_no_overfill_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s.count == FULL_CNT) |-> !wr.ready)
    else $error("fifo accepts while full");
  fifo_no_underrun_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s.count == '0) |-> !rd.valid)
    else $error("fifo offers data while empty");

endmodule : aig_fifo

/* File: design/aig_gen.sv */
// Acquisition indicator symbol generator: slot timing, signature combining, diversity
// Function
// - Output is a repeating train of 15 access slots of 40 bit intervals.
// - Each slot carries 32 real symbols, then 1024 silent chips.
// - Each signature indicator is +1, -1 or 0, supplied by access control.
// - Symbol j is the indicator-weighted sum of element j over sixteen signatures.
// - Fixed sixteen-row table of 32 elements; row 0 all +1, row 8 halves.
// - Diversity enabled: encode each signature sequence separately, then combine.
// - Preamble mode burst: 4096 chips of indicators, then 1024 chips silent.
// - Preamble mode uses the same weighted sum with ternary preamble indicators.
// - Preamble mode with diversity encodes each sequence before combining.
// - Preamble channel may share or not share the channelisation code.
module aig_gen
  import aig_pkg::*;
#(
  parameter int CHIPS_SYM = CHIPS_PER_SYM,
  parameter int CHIPS_GAP = GAP_CHIPS,
  parameter int CODE_BITS = CODE_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic gen_enable,
  input wire logic preamble_mode,
  input wire logic space_time_diversity_encoding_enable,
  input wire logic code_shared,
  input wire logic [CODE_BITS-1:0] code_acq,
  input wire logic [CODE_BITS-1:0] code_preamble,
  input wire logic [IND_W-1:0] ind_data,
  input wire logic ind_valid,
  output logic ind_ready,
  output logic tx_on,
  output logic sym_strobe,
  output logic signed [SYM_W-1:0] sym_ant1,
  output logic signed [SYM_W-1:0] sym_ant2,
  output logic [IDX_W-1:0] sym_index,
  output logic [SLOT_W-1:0] slot_index,
  output logic slot_start,
  output logic ind_missed,
  output logic [CODE_BITS-1:0] chan_code
);
  localparam logic [CNT_W-1:0] SYM_END = CNT_W'(CHIPS_SYM - 1);
  localparam logic [CNT_W-1:0] GAP_END = CNT_W'(CHIPS_GAP - 1);
  localparam int A_SYM = CHIPS_SYM;

  typedef struct packed {
    aig_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [IDX_W-1:0] idx;
    logic [SLOT_W-1:0] slot;
    logic [IND_W-1:0] ind;
    logic space_time_diversity_encoding;
    logic tx_on;
    logic strobe;
    logic slot_start;
    logic missed;
    logic signed [SYM_W-1:0] ant1;
    logic signed [SYM_W-1:0] ant2;
    logic [CODE_BITS-1:0] code;
  } aig_gen_s;

  aig_gen_s s;
  aig_gen_s next_s;
  logic pop;

  aig_stream_if #(.W(IND_W)) in_if ();
  aig_stream_if #(.W(IND_W)) out_if ();

  // ==========================================================================
  // Indicator sets queue up here; one set is drawn per access slot, so a source
  // running ahead of the air interface is held off by ind_ready
  assign in_if.data = ind_data;
  assign in_if.valid = ind_valid;
  assign ind_ready = in_if.ready;
  assign out_if.ready = pop;

  aig_fifo #(.W(IND_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr(in_if.snk),
    .rd(out_if.src)
  );

  // ==========================================================================
  // Slot sequencing and symbol combining
  always_comb begin
    next_s = s;
    next_s.strobe = 1'b0;
    next_s.slot_start = 1'b0;
    pop = 1'b0;
    case (s.st)
      AIG_IDLE: begin
        next_s.tx_on = 1'b0;
        next_s.ant1 = '0;
        next_s.ant2 = '0;
        next_s.slot = '0;
      end
      AIG_PART: begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == SYM_END) begin
          next_s.cnt = '0;
          if (s.idx == LAST_SYM) begin
            next_s.st = AIG_GAP;
            next_s.tx_on = 1'b0;
            next_s.ant1 = '0;
            next_s.ant2 = '0;
          end else begin
            next_s.idx = s.idx + 1'b1;
            next_s.strobe = 1'b1;
            next_s.ant1 = aig_sym_sum(s.ind, next_s.idx, 1'b0);
            next_s.ant2 = s.space_time_diversity_encoding ? aig_sym_sum(s.ind, next_s.idx, 1'b1) : '0;
          end
        end
      end
      AIG_GAP: begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == GAP_END) begin
          next_s.cnt = '0;
          next_s.st = AIG_IDLE;
          next_s.slot = (s.slot == LAST_SLOT) ? '0 : s.slot + 1'b1;
        end
      end
      default: begin
        next_s.st = AIG_IDLE;
      end
    endcase
    // A slot starts from idle, or straight after a gap so the train stays unbroken
    if (next_s.st == AIG_IDLE && gen_enable) begin
      pop = out_if.valid;
      next_s.st = AIG_PART;
      next_s.cnt = '0;
      next_s.idx = '0;
      // With no set queued the slot goes out with all indicators zero
      next_s.ind = out_if.valid ? out_if.data : '0;
      next_s.missed = ~out_if.valid;
      next_s.space_time_diversity_encoding = space_time_diversity_encoding_enable;
      next_s.code = (preamble_mode && !code_shared) ? code_preamble : code_acq;
      next_s.tx_on = 1'b1;
      next_s.strobe = 1'b1;
      next_s.slot_start = 1'b1;
      next_s.ant1 = aig_sym_sum(next_s.ind, '0, 1'b0);
      next_s.ant2 = space_time_diversity_encoding_enable ? aig_sym_sum(next_s.ind, '0, 1'b1) : '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: AIG_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign tx_on = s.tx_on;
  assign sym_strobe = s.strobe;
  assign sym_ant1 = s.ant1;
  assign sym_ant2 = s.ant2;
  assign sym_index = s.idx;
  assign slot_index = s.slot;
  assign slot_start = s.slot_start;
  assign ind_missed = s.missed;
  assign chan_code = s.code;

  // ==========================================================================
  // Helper counters read only by the checks below
  logic [MON_W-1:0] on_cnt;
  logic [MON_W-1:0] low_cnt;
  logic seen_part;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      on_cnt <= '0;
      low_cnt <= '0;
      seen_part <= 1'b0;
    end else begin
      on_cnt <= s.tx_on ? on_cnt + 1'b1 : '0;
      low_cnt <= s.tx_on ? '0 : low_cnt + 1'b1;
      if (s.tx_on) begin
        seen_part <= 1'b1;
      end else if (s.st == AIG_IDLE) begin
        seen_part <= 1'b0;
      end
    end
  end

  // Second model of the combiner for the checks: it builds every sequence from
  // signature and pair parity, so a bad table entry cannot hide behind itself
  function automatic logic signed [SYM_W-1:0] ref_sum(input logic [IND_W-1:0] ind,
                                                      input logic [IDX_W-1:0] j,
                                                      input logic ant2);
    logic signed [SYM_W-1:0] acc;
    logic [IDX_W-2:0] sig;
    logic neg;
    acc = '0;
    for (int n = 0; n < NUM_SIG; n++) begin
      sig = (IDX_W - 1)'(n);
      neg = (^(sig & j[IDX_W-1:1])) ^ (ant2 & ~j[0]);
      if (ind[2*n +: 2] == IND_POS) begin
        acc = neg ? acc - 6'sh01 : acc + 6'sh01;
      end else if (ind[2*n +: 2] == IND_NEG) begin
        acc = neg ? acc + 6'sh01 : acc - 6'sh01;
      end
    end
    return acc;
  endfunction : ref_sum

  // ==========================================================================
  gap_silent_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !tx_on |-> (sym_ant1 == '0 && sym_ant2 == '0))
    else $error("nonzero output outside indicator part");
  part_length_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(tx_on) |-> ($past(on_cnt) == MON_W'(SYM_PER_PART * CHIPS_SYM - 1)))
    else $error("indicator part length wrong");
  gap_length_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($rose(tx_on) && seen_part) |-> ($past(low_cnt) == MON_W'(CHIPS_GAP - 1)))
    else $error("gap length wrong");
  symbol_spacing_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sym_strobe && sym_index != LAST_SYM) |-> ##A_SYM (sym_strobe && sym_index == $past(sym_index, A_SYM) + 1'b1))
    else $error("symbol spacing wrong");
  last_symbol_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sym_strobe && sym_index == LAST_SYM) |-> tx_on ##A_SYM !tx_on)
    else $error("part did not end after last symbol");
  slot_train_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (slot_start && seen_part) |-> (slot_index == (($past(slot_index) == LAST_SLOT) ? '0 : $past(slot_index) + 1'b1)))
    else $error("access slot numbering wrong");
  combine_sum_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sym_strobe |-> (sym_ant1 == ref_sum(s.ind, sym_index, 1'b0)))
    else $error("symbol is not the weighted signature sum");
  diversity_sum_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sym_strobe |-> (sym_ant2 == (s.space_time_diversity_encoding ? ref_sum(s.ind, sym_index, 1'b1) : 6'sh00)))
    else $error("diversity branch wrong");
  code_select_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    slot_start |-> (chan_code == (($past(preamble_mode) && !$past(code_shared)) ?
                                  $past(code_preamble) : $past(code_acq))))
    else $error("channelisation code choice wrong");
  empty_slot_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (slot_start && ind_missed) |-> (sym_ant1 == '0 && sym_ant2 == '0))
    else $error("slot without indicators is not silent");
  strobe_in_part_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sym_strobe |-> tx_on)
    else $error("symbol strobe outside indicator part");

endmodule : aig_gen

/* File: bench/aig_ind_src.sv */
// Indicator source model: offers queued indicator sets on the valid/ready input
module aig_ind_src
  import aig_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ind_ready,
  output logic [IND_W-1:0] ind_data,
  output logic ind_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [IND_W-1:0] q[$];
  logic take;

  initial begin
    ind_valid = 1'b0;
    ind_data = 32'h0000_0000;
    take = 1'b0;
  end

  // Each word carries one ternary code per signature, exactly as queued
  task automatic push(input logic [IND_W-1:0] w);
    q.push_back(w);
  endtask : push

  // ==========================================================================
  // Handshake: a word is held until ready is sampled high with it
  always @(posedge clk_sys) begin
    take <= ind_valid && ind_ready && rst_n;
  end

  always @(negedge clk_sys) begin
    if (take && q.size() > 0) begin
      void'(q.pop_front());
    end
    if (q.size() > 0) begin
      ind_valid = 1'b1;
      ind_data = q[0];
    end else begin
      // Idle data toggles so nothing can lean on a stale word
      ind_valid = 1'b0;
      ind_data = ~ind_data;
    end
  end
endmodule : aig_ind_src

/* File: bench/aig_gen_tb.sv */
// Self-checking testbench for the acquisition indicator generator
module aig_gen_tb
  import aig_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Short symbol and gap counts keep a 36-slot run brief
  localparam int CS = 4;
  localparam int CG = 8;
  localparam int PER = SYM_PER_PART * CS + CG;

  logic clk_sys = 1'b0, rst_n = 1'b0, gen_enable = 1'b0;
  logic preamble_mode = 1'b0, space_time_diversity_encoding_enable = 1'b0, code_shared = 1'b0;
  logic [7:0] code_acq = 8'h5A, code_preamble = 8'hA5, chan_code;
  logic [IND_W-1:0] ind_data;
  logic ind_valid, ind_ready, tx_on, sym_strobe, slot_start, ind_missed;
  logic signed [SYM_W-1:0] sym_ant1, sym_ant2;
  logic [IDX_W-1:0] sym_index;
  logic [SLOT_W-1:0] slot_index;
  int miscompares = 0, compares = 0, cyc = 0, last_start = -1, nslot = 0;
  logic [31:0] exp_q[$];

  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  aig_gen #(.CHIPS_SYM(CS), .CHIPS_GAP(CG), .CODE_BITS(8)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .gen_enable(gen_enable), .preamble_mode(preamble_mode), .space_time_diversity_encoding_enable(space_time_diversity_encoding_enable),
    .code_shared(code_shared), .code_acq(code_acq), .code_preamble(code_preamble), .ind_data(ind_data),
    .ind_valid(ind_valid), .ind_ready(ind_ready), .tx_on(tx_on), .sym_strobe(sym_strobe),
    .sym_ant1(sym_ant1), .sym_ant2(sym_ant2), .sym_index(sym_index), .slot_index(slot_index),
    .slot_start(slot_start), .ind_missed(ind_missed), .chan_code(chan_code));

  aig_ind_src src (.clk_sys(clk_sys), .rst_n(rst_n), .ind_ready(ind_ready), .ind_data(ind_data),
    .ind_valid(ind_valid));

  // ==========================================================================
  // Shared helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done;
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic push(input logic [31:0] w);
    src.push(w);
    exp_q.push_back(w);
  endtask : push

  // Sequence element is -1 when signature and pair number share an odd count of bits
  function automatic int exp_sym(input logic [31:0] w, input int j, input logic ant2);
    int acc;
    int e;
    logic neg;
    acc = 0;
    e = ant2 ? (j ^ 1) : j;
    for (int s = 0; s < NUM_SIG; s++) begin
      neg = (^(s[3:0] & e[4:1])) ^ (ant2 && j % 2 == 0);
      if (w[2*s +: 2] == 2'h1) acc += neg ? -1 : 1;
      else if (w[2*s +: 2] == 2'h3) acc += neg ? 1 : -1;
    end
    return acc;
  endfunction : exp_sym

  function automatic logic [31:0] mk_word(input int k);
    case (k)
      0: return 32'h5555_5555;
      1: return 32'hFFFF_FFFF;
      2: return 32'h0000_0001;
      3: return 32'h0003_0000;
      default: return 32'((k + 1) * 32'h9E37_79B9);
    endcase
  endfunction : mk_word

  // ==========================================================================
  // Scenarios
  task automatic sc_fill;
    for (int k = 0; k < FIFO_DEPTH + 1; k++) push(mk_word(k));
    repeat (FIFO_DEPTH + 8) @(negedge clk_sys);
    check("full", ind_ready, 1'b0);
    check("held", ind_valid, 1'b1);
  endtask : sc_fill

  // One whole slot: controls latched at start, every symbol and the gap judged
  task automatic run_slot(input int k, input logic drop);
    logic [31:0] w;
    logic mode, dv, miss;
    int n;
    mode = k[0];
    dv = k[1];
    miss = (exp_q.size() == 0);
    w = 32'h0;
    if (!miss) w = exp_q.pop_front();
    preamble_mode = mode;
    space_time_diversity_encoding_enable = dv;
    code_shared = k[2];
    gen_enable = 1'b1;
    n = 0;
    while (slot_start !== 1'b1 && n < 2 * PER) begin
      @(negedge clk_sys);
      n++;
    end
    check("slot_start", slot_start, 1'b1);
    if (last_start >= 0) check("period", cyc - last_start, PER);
    last_start = cyc;
    if (drop) gen_enable = 1'b0;
    check("slot_index", slot_index, nslot);
    nslot = (nslot + 1) % SLOTS_PER_TRAIN;
    check("missed", ind_missed, miss);
    check("code", chan_code, (mode && !k[2]) ? code_preamble : code_acq);
    for (int j = 0; j < SYM_PER_PART; j++) begin
      check("index", {sym_strobe, tx_on, sym_index}, {2'b11, 5'(j)});
      check("ant1", 32'(sym_ant1), 32'(exp_sym(w, j, 1'b0)));
      check("ant2", 32'(sym_ant2), dv ? 32'(exp_sym(w, j, 1'b1)) : 32'h0);
      @(negedge clk_sys);
      check("mid", {sym_strobe, tx_on}, 2'b01);
      repeat (CS - 1) @(negedge clk_sys);
    end
    check("gap", {tx_on, sym_ant1, sym_ant2}, 32'h0);
    repeat (CG - 3) @(negedge clk_sys);
    check("gap_end", tx_on, 1'b0);
  endtask : run_slot

  // Generation must end after the slot in which enable fell
  task automatic sc_stop;
    int hits;
    hits = 0;
    // Queued while stopped, so it must still be waiting when generation restarts
    push(32'hC3A5_0F96);
    repeat (2 * PER) begin
      @(negedge clk_sys);
      if (tx_on !== 1'b0) hits++;
    end
    check("stopped", hits, 0);
    nslot = 0;
    last_start = -1;
  endtask : sc_stop

  // Outputs stay quiet and the FIFO open while reset is held
  task automatic sc_reset;
    repeat (5) @(negedge clk_sys);
    check("reset", {tx_on, sym_strobe, slot_start, ind_missed, sym_index, slot_index,
                    sym_ant1, sym_ant2}, 0);
    check("reset_ready", ind_ready, 1'b1);
    rst_n = 1'b1;
  endtask : sc_reset

  initial begin
    sc_reset();
    sc_fill();
    // 36 slots: train wraps twice, the last three find the queue empty
    for (int k = 0; k < 36; k++) run_slot(k, k == 35);
    sc_stop();
    run_slot(5, 1'b0);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    test_done();
  end
endmodule : aig_gen_tb
